/* rtl/scs_slave_port.sv */
`timescale 1ns/10ps
// Function
// - Byte and block, read and write accepted
// - Block bytes ascend from zero, MSB first
// - Host may stop after any byte
// - Answer slave address D2/D3 only
// - Command bit 7 selects block or byte
// - Command bits 6..0 index single bytes
// - Block write: acked command, count, data
// - Block read: count then data, NACK ends
// - Byte write: address, command, one byte
// - Byte read: one indexed byte returned
// - Config bytes load defaults at reset
module scs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_mclk,
  input  wire logic             i_srst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } scs_fifo_t;

  scs_fifo_t f_q;
  scs_fifo_t f_d;
  logic      push;
  logic      pop;

  assign o_in_ready  = (f_q.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (f_q.cnt != '0);
  assign o_out_data  = f_q.mem[f_q.rd];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    f_d = f_q;
    if (push) begin
      f_d.mem[f_q.wr] = i_in_data;
      f_d.wr          = (f_q.wr == AW'(DEPTH-1)) ? '0 : f_q.wr + 1'b1;
    end
    if (pop) begin
      f_d.rd = (f_q.rd == AW'(DEPTH-1)) ? '0 : f_q.rd + 1'b1;
    end
    f_d.cnt = f_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end
endmodule // scs_fifo

module scs_slave_port
  import scs_pkg::*;
(
  input  wire logic                   i_mclk,
  input  wire logic                   i_srst,
  input  wire logic                   i_scl,
  input  wire logic                   i_sda,
  output logic                        o_sda,
  output logic                        o_sda_oe_n,
  input  wire logic                   i_cfg_hold,
  output logic [CFG_BYTES*8-1:0]      o_cfg
);
  typedef struct packed {
    logic [1:0]                 scl_sync;
    logic [1:0]                 sda_sync;
    logic                       scl_prev;
    logic                       sda_prev;
    scs_state_t                 st;
    scs_phase_t                 ph;
    logic [3:0]                 cnt;
    logic [7:0]                 sh;
    logic                       blk;
    logic                       rd;
    logic [IDX_W-1:0]           ptr;
    logic                       push;
    logic [FIFO_WIDTH-1:0]      pdata;
    logic                       oe_n;
    logic                       pin_lo;
    logic [CFG_BYTES-1:0][7:0]  cfg;
  } scs_regs_t;

  scs_regs_t             r_q;
  scs_regs_t             r_d;
  logic                  f_ready;
  logic                  f_valid;
  logic [FIFO_WIDTH-1:0] f_data;
  logic                  scl;
  logic                  sda;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  start_c;
  logic                  stop_c;

  function automatic logic [7:0] rd_byte(input scs_regs_t r, input logic [IDX_W-1:0] i);
    rd_byte = (i < IDX_W'(CFG_BYTES)) ? r.cfg[i] : 8'h00;
  endfunction

  assign scl      = r_q.scl_sync[1];
  assign sda      = r_q.sda_sync[1];
  assign scl_rise = scl && !r_q.scl_prev;
  assign scl_fall = !scl && r_q.scl_prev;
  assign start_c  = scl && r_q.scl_prev && r_q.sda_prev && !sda;
  assign stop_c   = scl && r_q.scl_prev && !r_q.sda_prev && sda;

  // Full FIFO makes the data byte NACKed; the host sees back-pressure
  scs_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) scs_fifo_i (
    .i_mclk      (i_mclk),
    .i_srst      (i_srst),
    .i_in_valid  (r_q.push),
    .o_in_ready  (f_ready),
    .i_in_data   (r_q.pdata),
    .o_out_valid (f_valid),
    .i_out_ready (!i_cfg_hold),
    .o_out_data  (f_data)
  );

  always_comb begin
    r_d          = r_q;
    r_d.scl_sync = {r_q.scl_sync[0], i_scl};
    r_d.sda_sync = {r_q.sda_sync[0], i_sda};
    r_d.scl_prev = scl;
    r_d.sda_prev = sda;
    r_d.push     = 1'b0;
    r_d.pin_lo   = 1'b0;  // Open drain: only ever pulls low
    if (f_valid && !i_cfg_hold &&
        f_data[FIFO_WIDTH-1:8] < IDX_W'(CFG_BYTES)) begin
      r_d.cfg[f_data[FIFO_WIDTH-1:8]] = f_data[7:0];
    end
    if (start_c) begin  // Also a repeated start
      r_d.st   = SCS_RX;
      r_d.ph   = SCS_P_ADDR;
      r_d.cnt  = '0;
      r_d.oe_n = 1'b1;
    end else if (stop_c) begin
      r_d.st   = SCS_IDLE;
      r_d.oe_n = 1'b1;
    end else begin
      unique case (r_q.st)
        SCS_IDLE, SCS_SKIP: r_d.oe_n = 1'b1;
        SCS_RX: begin
          if (scl_rise && r_q.cnt != BITS_BYTE) begin
            r_d.sh  = {r_q.sh[6:0], sda};
            r_d.cnt = r_q.cnt + 4'h1;
          end else if (scl_fall && r_q.cnt == BITS_BYTE) begin
            r_d.cnt  = '0;
            r_d.st   = SCS_RX_ACK;
            r_d.oe_n = 1'b0;
            r_d.rd   = 1'b0;
            unique case (r_q.ph)
              SCS_P_ADDR: begin
                if (r_q.sh[7:1] != SLAVE_ADDR7) begin
                  r_d.st   = SCS_SKIP;
                  r_d.oe_n = 1'b1;
                end else begin
                  r_d.rd = r_q.sh[0];
                  r_d.ph = SCS_P_CMD;
                end
              end
              SCS_P_CMD: begin
                r_d.blk = !r_q.sh[CMD_SEL_BIT];
                r_d.ptr = r_q.sh[CMD_SEL_BIT] ? r_q.sh[6:0] : '0;
                r_d.ph  = r_q.sh[CMD_SEL_BIT] ? SCS_P_DATA : SCS_P_COUNT;
              end
              SCS_P_COUNT: r_d.ph = SCS_P_DATA;
              SCS_P_DATA: begin
                if (f_ready) begin
                  r_d.push  = 1'b1;
                  r_d.pdata = {r_q.ptr, r_q.sh};
                  r_d.ptr   = r_q.ptr + 1'b1;
                end else begin
                  r_d.st   = SCS_SKIP;
                  r_d.oe_n = 1'b1;
                end
              end
            endcase
          end
        end
        SCS_RX_ACK: begin
          if (scl_fall) begin
            r_d.oe_n = 1'b1;
            r_d.st   = SCS_RX;
            if (r_q.rd) begin
              r_d.st = SCS_TX;
              r_d.ph = SCS_P_DATA;
              if (r_q.blk) begin
                r_d.sh = BLOCK_COUNT;
              end else begin
                r_d.sh  = rd_byte(r_q, r_q.ptr);
                r_d.ptr = r_q.ptr + 1'b1;
              end
              r_d.oe_n = r_d.sh[7];
            end
          end
        end
        SCS_TX: begin
          if (scl_fall) begin
            if (r_q.cnt[2:0] == TX_LAST_BIT) begin
              r_d.oe_n = 1'b1;
              r_d.st   = SCS_TX_ACK;
              r_d.cnt  = '0;
            end else begin
              r_d.sh   = {r_q.sh[6:0], 1'b0};
              r_d.oe_n = r_q.sh[6];
              r_d.cnt  = r_q.cnt + 4'h1;
            end
          end
        end
        SCS_TX_ACK: begin
          if (scl_rise) begin
            if (sda) begin
              r_d.st = SCS_SKIP;
            end else begin
              r_d.st  = SCS_TX_LOAD;
              r_d.sh  = rd_byte(r_q, r_q.ptr);
              r_d.ptr = r_q.ptr + 1'b1;
            end
          end
        end
        SCS_TX_LOAD: begin
          if (scl_fall) begin
            r_d.st   = SCS_TX;
            r_d.oe_n = r_q.sh[7];
          end
        end
        default: r_d.st = SCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      r_q          <= '0;
      r_q.scl_sync <= 2'h3;
      r_q.sda_sync <= 2'h3;
      r_q.scl_prev <= 1'b1;
      r_q.sda_prev <= 1'b1;
      r_q.st       <= SCS_IDLE;
      r_q.ph       <= SCS_P_ADDR;
      r_q.oe_n     <= 1'b1;
      r_q.cfg      <= CFG_DEFAULT;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs are the state flops themselves
  assign o_sda      = r_q.pin_lo;
  assign o_sda_oe_n = r_q.oe_n;
  assign o_cfg      = r_q.cfg;
endmodule // scs_slave_port

/* inc/scs_pkg.sv */
package scs_pkg;
  localparam int          CFG_BYTES   = 7;
  localparam int          IDX_W       = 7;
  localparam logic [6:0]  SLAVE_ADDR7 = 7'h69;  // Write form D2
  localparam logic [7:0]  BLOCK_COUNT = 8'h07;
  localparam logic [3:0]  BITS_BYTE   = 4'h8;
  localparam logic [2:0]  TX_LAST_BIT = 3'h7;
  localparam int          CMD_SEL_BIT = 7;
  localparam int          FIFO_DEPTH  = 4;
  localparam int          FIFO_WIDTH  = IDX_W + 8;
  // Power-on values, byte 0 in the low bits
  localparam logic [CFG_BYTES*8-1:0] CFG_DEFAULT = 56'h00_00_00_EB_7F_FF_00;

  typedef enum logic [2:0] {
    SCS_IDLE, SCS_RX, SCS_RX_ACK, SCS_TX, SCS_TX_ACK, SCS_TX_LOAD, SCS_SKIP
  } scs_state_t;

  typedef enum logic [1:0] {
    SCS_P_ADDR, SCS_P_CMD, SCS_P_COUNT, SCS_P_DATA
  } scs_phase_t;
endpackage

/* sim/scs_chk.sv */
`timescale 1ns/10ps
module scs_chk
  import scs_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_srst,
  input wire logic        i_scl,
  input wire logic        i_sda,
  input wire logic        o_sda,
  input wire logic        o_sda_oe_n,
  input wire logic        i_cfg_hold,
  input wire logic [55:0] o_cfg
);
  logic       act_q;
  logic [3:0] bits_q;
  logic [8:0] sh_q;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // Raw pins, so frame edges lead the device
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      act_q  <= 1'h0;
      bits_q <= 4'h0;
    end else if (i_scl && $fell(i_sda)) begin
      act_q  <= 1'h1;
      bits_q <= 4'h0;
    end else if (i_scl && $rose(i_sda)) begin
      act_q <= 1'h0;
    end else if ($rose(i_scl)) begin
      sh_q   <= {sh_q[7:0], i_sda};
      bits_q <= (bits_q < 4'hA) ? bits_q + 4'h1 : bits_q;
    end
  end
  property p_od; o_sda == 1'h0; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_rst; $fell(i_srst) |-> o_cfg == CFG_DEFAULT && o_sda_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_quiet; act_q && bits_q < 4'h8 |-> o_sda_oe_n; endproperty
  a_quiet: assert property (p_quiet) else $error("drive in address");
  property p_ack; bits_q == 4'h9 && $fell(i_scl) |-> o_sda_oe_n == (sh_q[8:2] != SLAVE_ADDR7);
  endproperty
  a_ack: assert property (p_ack) else $error("bad address ack");
  property p_idle; !act_q |-> o_sda_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("drive outside frame");
  property p_edge; $changed(o_sda_oe_n) |-> !i_scl; endproperty
  a_edge: assert property (p_edge) else $error("change while clock high");
  property p_hold; i_cfg_hold [*2] |=> $stable(o_cfg); endproperty
  a_hold: assert property (p_hold) else $error("drain while held");
  property p_addr; act_q && bits_q < 4'h9 |-> $stable(o_cfg); endproperty
  a_addr: assert property (p_addr) else $error("write before data");
endmodule // scs_chk
bind scs_slave_port scs_chk scs_chk_i (.i_mclk(i_mclk), .i_srst(i_srst), .i_scl(i_scl),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_cfg_hold(i_cfg_hold),
  .o_cfg(o_cfg));

/* sim/scs_hm.sv */
`timescale 1ns/10ps
module scs_hm (
  input  wire logic i_mclk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  // Start when s is 1, stop when 0; late edge lets the ack go first
  task automatic cond(input logic s);
    tick(1);
    o_sda = s;
    tick(5);
    o_scl = 1'h1;
    tick(4);
    o_sda = !s;
    tick(4);
    o_scl = !s;
  endtask
  // Low 5 cycles so the answer lands before the rise
  task automatic bt(input logic b, output logic q);
    tick(1);
    o_sda = b;
    tick(4);
    o_scl = 1'h1;
    tick(3);
    q = i_sda;
    o_scl = 1'h0;
  endtask
  task automatic xf(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(ai, a);
  endtask
endmodule // scs_hm

/* sim/scs_slave_port_tb_top.sv */
`timescale 1ns/10ps
module scs_slave_port_tb_top
  import scs_pkg::*;
;
  logic        mclk = 1'h0;
  logic        srst;
  logic        hold;
  logic        scl;
  logic        hsda;
  logic        dsda;
  logic        oe_n;
  logic [55:0] cfg;
  logic [55:0] ec;
  wire         sda = hsda & (oe_n | dsda);
  int          bad_count;
  int          n_tests;
  always #20 mclk = ~mclk;
  scs_hm scs_hm_i (.i_mclk(mclk), .i_sda(sda), .o_scl(scl), .o_sda(hsda));
  scs_slave_port scs_slave_port_i (.i_mclk(mclk), .i_srst(srst), .i_scl(scl), .i_sda(sda),
    .o_sda(dsda), .o_sda_oe_n(oe_n), .i_cfg_hold(hold), .o_cfg(cfg));
  task automatic check(input string nm, input logic [55:0] s, input logic [55:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic sb(input logic [7:0] d, input logic ea);
    logic [7:0] q;
    logic       a;
    scs_hm_i.xf(d, 1'h1, q, a);
    check("ack", {55'h0, a}, {55'h0, ea});
  endtask
  task automatic rb(input logic nk, input logic [7:0] e);
    logic [7:0] q;
    logic       a;
    scs_hm_i.xf(8'hFF, nk, q, a);
    check("rdata", {48'h0, q}, {48'h0, e});
  endtask
  // Start when s is 1, stop when 0
  task automatic frame(input logic s);
    scs_hm_i.cond(s);
  endtask
  task automatic hd(input logic [7:0] c, input logic rd);
    frame(1'h1);
    sb(8'hD2, 1'h0);
    sb(c, 1'h0);
    if (rd) begin
      frame(1'h1);
      sb(8'hD3, 1'h0);
    end
  endtask
  task automatic ck_cfg();
    repeat (8) @(negedge mclk);
    check("cfg", cfg, ec);
  endtask
  task automatic t_reset();
    srst = 1'h1;
    repeat (3) @(negedge mclk);
    srst = 1'h0;
    ec = CFG_DEFAULT;
    ck_cfg();
  endtask
  task automatic t_byte();
    hd(8'h81, 1'h0);
    sb(8'h55, 1'h0);
    frame(1'h0);
    ec[15:8] = 8'h55;
    ck_cfg();
    hd(8'h83, 1'h1);
    rb(1'h1, 8'hEB);
    frame(1'h0);
  endtask
  task automatic t_block();
    hd(8'h00, 1'h0);
    sb(8'h07, 1'h0);
    sb(8'hA1, 1'h0);
    sb(8'hA2, 1'h0);
    frame(1'h0);
    ec[15:0] = 16'hA2A1;
    ck_cfg();
    hd(8'h00, 1'h1);
    rb(1'h0, BLOCK_COUNT);
    rb(1'h0, 8'hA1);
    rb(1'h1, 8'hA2);
    frame(1'h0);
  endtask
  // Index past the last byte: write dropped, read gives zero
  task automatic t_range();
    hd(8'h89, 1'h0);
    sb(8'h5A, 1'h0);
    frame(1'h0);
    ck_cfg();
    hd(8'h89, 1'h1);
    rb(1'h1, 8'h00);
    frame(1'h0);
  endtask
  task automatic t_foreign();
    frame(1'h1);
    sb(8'hD4, 1'h1);
    sb(8'h80, 1'h1);
    frame(1'h0);
    ck_cfg();
  endtask
  // Stalled drain fills the buffer so the fifth byte is refused
  task automatic t_full();
    hold = 1'h1;
    hd(8'h00, 1'h0);
    sb(8'h07, 1'h0);
    for (int i = 0; i < 5; i++) sb(8'hC0 + 8'(i), i == 4);
    frame(1'h0);
    ck_cfg();
    hold = 1'h0;
    ec[31:0] = 32'hC3C2C1C0;
    ck_cfg();
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    final_report();
  end
  initial begin
    hold = 1'h0;
    t_reset();
    t_byte();
    t_block();
    t_range();
    t_foreign();
    t_full();
    t_reset();
    t_byte();
    final_report();
  end
endmodule // scs_slave_port_tb_top
